// ### hw/cscirq_defines.svh
/*
 * constants for the card status-change interrupt block: register indexes,
 * field positions, reset values and routing codes.
 * assumes it is included by bare name from hw/ design files.
 */
// Operation
// - a disabled source's flag always reads 0
// - an enabled source sets its flag when active and raises interrupt
// - flags clear either on register read or by writing 1
// - global control bit 2 selects clear-on-read versus write-one-to-clear
// - flag register bits 7 to 4 always read zero
// - bit 3 sets on any change of either card-detect input
// - memory card: bit 2 sets on READY low-to-high transition
// - I/O card forces bits 2 and 1 to read 0
// - memory card: bit 1 sets on battery-low warning
// - memory card: bit 0 follows status-change signal, 1 while asserted; the code sets it on the assertion edge and holds it until cleared
// - ring-indicate mode: bit 0 shows ring-indicate input; the code sets it on the assertion edge and holds it until cleared
// - flag register at index 04h (A), 44h (B), window offset 804h
// - selector bits 7-4 route: 0001 IRQ1, 0010 SYSTEM_MGMT_IRQ, 0011-1111 IRQ3-15
// - selector 0000 with diagnostic bit 5 set routes to host bus
// - selector 0000, diagnostic bit clear: no ISA routing; route bit still works
// - config bit 3 enables card-detect change interrupt, reset 0
// - config bit 2 enables READY rise interrupt
// - config bit 1 enables battery warning interrupt, default 0
// - config bit 0 enables battery-dead or status-change interrupt
// - general control bit 4 sends interrupt to host bus interrupts
// - card-type bit 0 memory card, 1 I/O card
// - battery-voltage input is ring-indicate only while bit 7 set
`ifndef CSCIRQ_DEFINES_SVH
`define CSCIRQ_DEFINES_SVH

// ------------------------------------------------------------
// register indexes
// ------------------------------------------------------------
`define CSC_IDX_GEN 8'h03
`define CSC_IDX_FLAGS 8'h04
`define CSC_IDX_CFG 8'h05
`define CSC_IDX_SOCK_B 8'h40
`define CSC_WIN_BASE 12'h0800
`define CSC_RESET_VAL 8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CSC_B_DETECT 3
`define CSC_B_READY 2
`define CSC_B_BATLOW 1
`define CSC_B_BATTERY_DEAD_FLAG 0
`define CSC_GEN_RING 7
`define CSC_GEN_IOCARD 5
`define CSC_GEN_ROUTE 4
`define CSC_GLB_CLRMODE 2
`define CSC_DIAG_CSC 5
`define CSC_SEL_HI 7
`define CSC_SEL_LO 4

// ------------------------------------------------------------
// routing codes
// ------------------------------------------------------------
`define CSC_SEL_NONE 4'h0
`define CSC_SEL_IRQ1 4'h1
`define CSC_SEL_SMI 4'h2

`endif

// ### hw/cscirq_flag.sv
/*
 * one sticky status-change flag with set-over-clear priority.
 * assumes set, clear and enable are on clk.
 */
`default_nettype none
module cscirq_flag
	import cscirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic set,
	input wire logic clr,
	output logic flag
);
	// a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clk)
	begin
		if (rst)
			flag <= 1'b0;
		else if (en && set)
			flag <= 1'b1;
		else if (clr || !en)
			flag <= 1'b0;
	end
endmodule
`default_nettype wire

// ### hw/cscirq_pkg.sv
/*
 * types for the card status-change interrupt block.
 * assumes the defines header sits beside it.
 */
`default_nettype none
package cscirq_pkg;
	typedef logic [7:0] cscirq_byte_t;
	typedef logic [3:0] cscirq_flags_t;
endpackage
`default_nettype wire

// ### hw/cscirq_sync.sv
/*
 * two flip-flop synchroniser for one card pin.
 * assumes the pin is asynchronous to clk.
 */
`default_nettype none
module cscirq_sync
	import cscirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic q
);
	logic meta;

	// meta feeds only q, nothing else looks at it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta <= pin;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ### hw/cscirq_top.sv
/*
 * card status-change flags, enables and interrupt routing for two sockets'
 * index space; this instance serves one socket at index base sock_b.
 * assumes a simple synchronous index port: reg_rd/reg_wr one-cycle strobes
 * with reg_idx; read data registered one cycle later with reg_rvalid.
 * card pins are asynchronous and are synchronised here.
 */
`default_nettype none
`include "cscirq_defines.svh"
module cscirq_top
	import cscirq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sock_b,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic reg_win,
	input wire logic [11:0] reg_idx,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic flag_clr_mode,
	input wire logic diag_csc_route,
	input wire logic card_present_n_a,
	input wire logic card_present_n_b,
	input wire logic card_ready_in,
	input wire logic battery_warn_in,
	input wire logic battery_voltage_in,
	input wire logic card_state_changed_n,
	output logic [15:0] isa_irq,
	output logic system_mgmt_irq,
	output logic event_to_host_bus_irq
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	cscirq_byte_t gen_ctrl;
	cscirq_byte_t irq_cfg;
	cscirq_flags_t flags;
	cscirq_flags_t flag_set;
	cscirq_flags_t flag_en;
	logic clr_mode_q;
	logic diag_q;
	logic cd_a;
	logic cd_b;
	logic rdy;
	logic batw;
	logic bvd;
	logic card_state_changed_n_n;
	logic cd_a_d;
	logic cd_b_d;
	logic rdy_d;
	logic batw_d;
	logic io_card;
	logic ring_mode;
	logic bit0_src;
	logic bit0_d;
	logic any_flag;
	logic [3:0] route_sel;
	logic [7:0] base;
	logic hit_gen;
	logic hit_flags;
	logic hit_cfg;
	logic rd_flags;
	logic [3:0] w1c;
	cscirq_byte_t next_rdata;
	cscirq_flags_t flag_view;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	cscirq_sync u_cda (.clk(clk), .rst(rst), .pin(card_present_n_a), .q(cd_a));
	cscirq_sync u_cdb (.clk(clk), .rst(rst), .pin(card_present_n_b), .q(cd_b));
	cscirq_sync u_rdy (.clk(clk), .rst(rst), .pin(card_ready_in), .q(rdy));
	cscirq_sync u_bw (.clk(clk), .rst(rst), .pin(battery_warn_in), .q(batw));
	cscirq_sync u_bvd (.clk(clk), .rst(rst), .pin(battery_voltage_in), .q(bvd));
	cscirq_sync u_sc (.clk(clk), .rst(rst), .pin(card_state_changed_n), .q(card_state_changed_n_n));

	// mode inputs are treated as asynchronous straps as well
	cscirq_sync u_clm (.clk(clk), .rst(rst), .pin(flag_clr_mode), .q(clr_mode_q));
	cscirq_sync u_dg (.clk(clk), .rst(rst), .pin(diag_csc_route), .q(diag_q));

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign base = sock_b ? `CSC_IDX_SOCK_B : `CSC_RESET_VAL;
	// window accesses use base plus index, socket spacing handled outside
	always_comb
	begin
		if (reg_win)
		begin
			hit_gen = (reg_idx == (`CSC_WIN_BASE | 12'(`CSC_IDX_GEN)));
			hit_flags = (reg_idx == (`CSC_WIN_BASE | 12'(`CSC_IDX_FLAGS)));
			hit_cfg = (reg_idx == (`CSC_WIN_BASE | 12'(`CSC_IDX_CFG)));
		end
		else
		begin
			hit_gen = (reg_idx == {4'h0, base | `CSC_IDX_GEN});
			hit_flags = (reg_idx == {4'h0, base | `CSC_IDX_FLAGS});
			hit_cfg = (reg_idx == {4'h0, base | `CSC_IDX_CFG});
		end
	end

	assign rd_flags = reg_rd && hit_flags;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			gen_ctrl <= `CSC_RESET_VAL;
		else if (reg_wr && hit_gen)
			gen_ctrl <= reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			irq_cfg <= `CSC_RESET_VAL;
		else if (reg_wr && hit_cfg)
			irq_cfg <= reg_wdata;
	end

	assign io_card = gen_ctrl[`CSC_GEN_IOCARD];
	assign ring_mode = gen_ctrl[`CSC_GEN_RING];
	assign route_sel = irq_cfg[`CSC_SEL_HI:`CSC_SEL_LO];

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cd_a_d <= 1'b0;
			cd_b_d <= 1'b0;
			rdy_d <= 1'b0;
			batw_d <= 1'b0;
			// bit 0 pins idle high but sync low after reset; start high so release is no edge
			bit0_d <= 1'b1;
		end
		else
		begin
			cd_a_d <= cd_a;
			cd_b_d <= cd_b;
			rdy_d <= rdy;
			batw_d <= batw;
			bit0_d <= bit0_src;
		end
	end

	// ring input shares the battery-voltage pin
	assign bit0_src = ring_mode ? !bvd : !card_state_changed_n_n;

	always_comb
	begin
		flag_set = '0;
		flag_set[`CSC_B_DETECT] = (cd_a ^ cd_a_d) | (cd_b ^ cd_b_d);
		flag_set[`CSC_B_READY] = !io_card && rdy && !rdy_d;
		flag_set[`CSC_B_BATLOW] = !io_card && batw && !batw_d;
		flag_set[`CSC_B_BATTERY_DEAD_FLAG] = bit0_src && !bit0_d;
	end

	always_comb
	begin
		flag_en = irq_cfg[3:0];
		if (io_card)
		begin
			flag_en[`CSC_B_READY] = 1'b0;
			flag_en[`CSC_B_BATLOW] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// flag clearing
	// ------------------------------------------------------------
	// mode 1 is write-one-to-clear, mode 0 clear-on-read
	always_comb
	begin
		w1c = '0;
		if (clr_mode_q)
		begin
			if (reg_wr && hit_flags)
				w1c = reg_wdata[3:0];
		end
		else if (rd_flags)
			w1c = 4'hf;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_flag
			cscirq_flag u_flag (
				.clk(clk),
				.rst(rst),
				.en(flag_en[g]),
				.set(flag_set[g]),
				.clr(w1c[g]),
				.flag(flags[g])
			);
		end
	endgenerate

	assign flag_view = flags & flag_en;

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = `CSC_RESET_VAL;
		if (hit_gen)
			next_rdata = gen_ctrl;
		else if (hit_flags)
			next_rdata = {4'h0, flag_view};
		else if (hit_cfg)
			next_rdata = irq_cfg;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata <= `CSC_RESET_VAL;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? next_rdata : `CSC_RESET_VAL;
			reg_rvalid <= reg_rd;
		end
	end

	// ------------------------------------------------------------
	// interrupt routing
	// ------------------------------------------------------------
	// level output: holds while any enabled flag is set
	assign any_flag = |flag_view;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			isa_irq <= 16'h0000;
			system_mgmt_irq <= 1'b0;
			event_to_host_bus_irq <= 1'b0;
		end
		else
		begin
			isa_irq <= 16'h0000;
			system_mgmt_irq <= 1'b0;
			if (gen_ctrl[`CSC_GEN_ROUTE] ||
				(route_sel == `CSC_SEL_NONE && diag_q))
				event_to_host_bus_irq <= any_flag;
			else
			begin
				event_to_host_bus_irq <= 1'b0;
				if (route_sel == `CSC_SEL_SMI)
					system_mgmt_irq <= any_flag;
				else if (route_sel != `CSC_SEL_NONE)
					isa_irq[route_sel] <= any_flag;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
		reg_rvalid |-> reg_rdata[7:4] == 4'h0 || !$past(hit_flags))
		else $error("flag register upper bits not zero");
	disabled_zero_a: assert property (@(posedge clk) disable iff (rst)
		(flags & ~flag_en) == 4'h0 || $past(flag_en) != flag_en)
		else $error("disabled flag held");
	detect_sets_a: assert property (@(posedge clk) disable iff (rst)
		flag_en[`CSC_B_DETECT] && (cd_a != cd_a_d) ##1 flag_en[`CSC_B_DETECT]
		|-> flags[`CSC_B_DETECT])
		else $error("detect change lost");
	io_masks_a: assert property (@(posedge clk) disable iff (rst)
		io_card |-> flag_view[2:1] == 2'b00)
		else $error("io card shows memory flags");
	read_clears_a: assert property (@(posedge clk) disable iff (rst)
		rd_flags && !clr_mode_q && flag_set == 4'h0 |=> flags == 4'h0)
		else $error("read did not clear");
	w1c_clears_a: assert property (@(posedge clk) disable iff (rst)
		reg_wr && hit_flags && clr_mode_q && reg_wdata[0] && !flag_set[0]
		|=> !flags[0])
		else $error("write one did not clear");
	irq_level_a: assert property (@(posedge clk) disable iff (rst)
		any_flag && route_sel == `CSC_SEL_SMI && !gen_ctrl[`CSC_GEN_ROUTE]
		##1 $stable(irq_cfg) && $stable(gen_ctrl) |-> system_mgmt_irq)
		else $error("smi not held");
	host_route_a: assert property (@(posedge clk) disable iff (rst)
		gen_ctrl[`CSC_GEN_ROUTE] |=> !system_mgmt_irq && isa_irq == 16'h0000)
		else $error("host route leaked to isa");
	ready_rise_a: assert property (@(posedge clk) disable iff (rst)
		flag_en[`CSC_B_READY] && rdy && !rdy_d ##1 flag_en[`CSC_B_READY]
		|-> flags[`CSC_B_READY])
		else $error("ready rise lost");
	battery_low_a: assert property (@(posedge clk) disable iff (rst)
		flag_en[`CSC_B_BATLOW] && batw && !batw_d |=> flags[`CSC_B_BATLOW])
		else $error("battery warning lost");
	dead_sets_a: assert property (@(posedge clk) disable iff (rst)
		flag_en[`CSC_B_BATTERY_DEAD_FLAG] && bit0_src && !bit0_d |=> flags[`CSC_B_BATTERY_DEAD_FLAG])
		else $error("status change lost");
	read_keeps_a: assert property (@(posedge clk) disable iff (rst)
		rd_flags && clr_mode_q && !reg_wr && flag_en[0] && flags[0] |=> flags[0])
		else $error("read cleared in write-one mode");
	isa_route_a: assert property (@(posedge clk) disable iff (rst)
		any_flag && !gen_ctrl[`CSC_GEN_ROUTE] && route_sel > `CSC_SEL_SMI
		|=> $onehot(isa_irq) && isa_irq[$past(route_sel)])
		else $error("isa line not selected");
	diag_route_a: assert property (@(posedge clk) disable iff (rst)
		any_flag && route_sel == `CSC_SEL_NONE && diag_q |=> event_to_host_bus_irq)
		else $error("diagnostic route missing");
	no_route_a: assert property (@(posedge clk) disable iff (rst)
		route_sel == `CSC_SEL_NONE && !diag_q && !gen_ctrl[`CSC_GEN_ROUTE]
		|=> !event_to_host_bus_irq && !system_mgmt_irq && isa_irq == 16'h0000)
		else $error("interrupt routed with no route");
	host_raise_a: assert property (@(posedge clk) disable iff (rst)
		any_flag && gen_ctrl[`CSC_GEN_ROUTE] |=> event_to_host_bus_irq)
		else $error("host bus interrupt missing");

	cov_smi_c: cover property (@(posedge clk) system_mgmt_irq);
	cov_host_c: cover property (@(posedge clk) event_to_host_bus_irq);
	cov_isa_c: cover property (@(posedge clk) isa_irq[15]);
	cov_w1c_c: cover property (@(posedge clk) |w1c && clr_mode_q);
endmodule
`default_nettype wire

// ### tb/cscirq_card_model.sv
/*
 * model of the card in the socket: drives the six card pins of the block.
 * assumes the bench calls pulse() and that pins start at their idle levels.
 */
`default_nettype none
module cscirq_card_model
(
	input wire logic clk,
	output logic card_present_n_a,
	output logic card_present_n_b,
	output logic card_ready_in,
	output logic battery_warn_in,
	output logic battery_voltage_in,
	output logic card_state_changed_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// card present, ready low, no warning, ring and status-change idle high
	logic [5:0] pins = 6'h30;
	assign {card_state_changed_n, battery_voltage_in, battery_warn_in, card_ready_in,
		card_present_n_b, card_present_n_a} = pins;
	// --------------------------------------------------------
	// one pin away from its idle level and back
	// --------------------------------------------------------
	// each half lasts long enough to pass the synchroniser; ends at a falling edge
	task automatic pulse(input int k);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			pins[k] <= ~pins[k];
			repeat (6) @(posedge clk);
		end
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 * self-checking bench for the card status-change interrupt block.
 * assumes the card model drives the pins and the index port per the hand-over.
 */
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	import cscirq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, sock_b, reg_rd, reg_wr, reg_win;
	logic [11:0] reg_idx;
	logic [7:0] reg_wdata, d, reg_rdata;
	logic flag_clr_mode, diag_csc_route, reg_rvalid, system_mgmt_irq;
	logic event_to_host_bus_irq;
	logic [15:0] isa_irq;
	wire card_present_n_a, card_present_n_b, card_ready_in, battery_warn_in;
	wire battery_voltage_in, card_state_changed_n;
	int n_fail = 0, comparisons = 0;
	always #50 clk = ~clk;
	cscirq_top dut (.clk, .rst, .sock_b, .reg_rd, .reg_wr, .reg_win, .reg_idx, .reg_wdata,
		.reg_rdata, .reg_rvalid, .flag_clr_mode, .diag_csc_route, .card_present_n_a,
		.card_present_n_b, .card_ready_in, .battery_warn_in, .battery_voltage_in,
		.card_state_changed_n, .isa_irq, .system_mgmt_irq, .event_to_host_bus_irq);
	cscirq_card_model card (.clk, .card_present_n_a, .card_present_n_b, .card_ready_in,
		.battery_warn_in, .battery_voltage_in, .card_state_changed_n);
	// --------------------------------------------------------
	// index port access; bit 12 of the address selects the window
	// --------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1;
		reg_win <= a[12];
		reg_idx <= a[11:0];
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	// read data stands one cycle only, so it is taken at the first falling edge with rvalid
	task automatic rd(input logic [12:0] a, output logic [7:0] v);
		int i;
		@(posedge clk);
		reg_rd <= 1;
		reg_win <= a[12];
		reg_idx <= a[11:0];
		@(posedge clk);
		reg_rd <= 0;
		i = 0;
		do
		begin
			@(negedge clk);
			i++;
		end
		while (reg_rvalid !== 1'b1 && i < 4);
		if (reg_rvalid !== 1'b1)
		begin
			n_fail++;
			final_report();
		end
		v = reg_rdata;
	endtask
	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_reset;
		rd(13'h0004, d);
		`CHK(d, 8'h00)
		rd(13'h0005, d);
		`CHK(d, 8'h00)
		`CHK({isa_irq, system_mgmt_irq, event_to_host_bus_irq}, 18'h0_0000)
	endtask
	// every nonzero selector code, 1 to 15, alternating the two card-detect pins
	task automatic t_route;
		for (int c = 1; c < 16; c++)
		begin
			wr(13'h0005, {c[3:0], 4'h8});
			card.pulse(c % 2);
			`CHK(isa_irq, (c == 2) ? 16'h0000 : 16'(1 << c))
			`CHK(system_mgmt_irq, c == 2)
			rd(13'h0004, d);
			`CHK(d, 8'h08)
			repeat (3) @(negedge clk);
			`CHK({isa_irq, system_mgmt_irq}, 17'h0_0000)
			rd(13'h0004, d);
			`CHK(d, 8'h00)
		end
	endtask
	task automatic t_mask;
		wr(13'h0005, 8'h30);
		for (int k = 0; k < 6; k++)
			card.pulse(k);
		`CHK(isa_irq, 16'h0000)
		rd(13'h0004, d);
		`CHK(d, 8'h00)
	endtask
	// write-one-to-clear: reads leave the flag, only a 1 in its place clears it
	task automatic t_w1c;
		@(posedge clk);
		flag_clr_mode <= 1;
		wr(13'h0005, 8'h24);
		card.pulse(2);
		`CHK(system_mgmt_irq, 1'b1)
		rd(13'h0004, d);
		rd(13'h0004, d);
		`CHK(d, 8'h04)
		wr(13'h0004, 8'h0B);
		rd(13'h0004, d);
		`CHK(d, 8'h04)
		wr(13'h0004, 8'h04);
		repeat (3) @(negedge clk);
		`CHK(system_mgmt_irq, 1'b0)
		rd(13'h0004, d);
		`CHK(d, 8'h00)
		@(posedge clk);
		flag_clr_mode <= 0;
	endtask
	task automatic t_card;
		wr(13'h0005, 8'h17);
		card.pulse(3);
		rd(13'h0004, d);
		`CHK(d, 8'h02)
		card.pulse(5);
		`CHK(isa_irq, 16'h0002)
		rd(13'h0004, d);
		`CHK(d, 8'h01)
		wr(13'h0003, 8'h20);
		card.pulse(2);
		card.pulse(3);
		`CHK(isa_irq, 16'h0000)
		rd(13'h0004, d);
		`CHK(d, 8'h00)
		wr(13'h0003, 8'h00);
	endtask
	// diag bit, route bit and selector decide the host-bus path
	task automatic t_host;
		logic [2:0] cfg[3] = '{3'b100, 3'b011, 3'b000};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			diag_csc_route <= cfg[i][2];
			wr(13'h0003, {3'h0, cfg[i][1], 4'h0});
			wr(13'h0005, {2'h0, cfg[i][0], cfg[i][0], 4'h1});
			card.pulse(5);
			`CHK(event_to_host_bus_irq, i != 2)
			`CHK(isa_irq, 16'h0000)
			rd(13'h0004, d);
		end
		@(posedge clk);
		diag_csc_route <= 0;
		wr(13'h0003, 8'h00);
	endtask
	task automatic t_ring;
		wr(13'h0003, 8'h80);
		wr(13'h0005, 8'h31);
		card.pulse(4);
		`CHK(isa_irq, 16'h0008)
		rd(13'h0004, d);
		`CHK(d, 8'h01)
		wr(13'h0003, 8'h00);
		card.pulse(4);
		rd(13'h0004, d);
		`CHK(d, 8'h00)
	endtask
	task automatic t_addr;
		wr(13'h1805, 8'h5A);
		rd(13'h1805, d);
		`CHK(d, 8'h5A)
		@(posedge clk);
		sock_b <= 1;
		rd(13'h0045, d);
		`CHK(d, 8'h5A)
		wr(13'h0005, 8'hFF);
		rd(13'h0005, d);
		`CHK(d, 8'h00)
		rd(13'h0045, d);
		`CHK(d, 8'h5A)
		@(posedge clk);
		sock_b <= 0;
	endtask
	initial
	begin
		sock_b <= 1'b0;
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		reg_win <= 1'b0;
		reg_idx <= 12'h000;
		reg_wdata <= 8'h00;
		flag_clr_mode <= 1'b0;
		diag_csc_route <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 0;
		t_reset();
		t_route();
		t_mask();
		t_w1c();
		t_card();
		t_host();
		t_ring();
		t_addr();
		final_report();
	end
endmodule
`default_nettype wire
